// [design/rcr_pkg.sv]
// constants shared by the regulator control register bank
package rcr_pkg;

   localparam int unsigned ADDR_W = 12;
   localparam int unsigned DATA_W = 32;
   localparam int unsigned REG_W = 8;
   localparam int unsigned IDX_W = 10;
   localparam int unsigned VCODE_W = 6;
   localparam int unsigned DLY_W = 3;
   localparam int unsigned NUM_CH = 3;

   // printed offsets are register indices; byte address is index * 4
   localparam logic [IDX_W-1:0] IDX_B2_MAIN = 10'h030;
   localparam logic [IDX_W-1:0] IDX_B2_ALT = 10'h031;
   localparam logic [IDX_W-1:0] IDX_B2_CTRL = 10'h032;
   localparam logic [IDX_W-1:0] IDX_B3_MAIN = 10'h040;
   localparam logic [IDX_W-1:0] IDX_B3_ALT = 10'h041;
   localparam logic [IDX_W-1:0] IDX_B3_CTRL = 10'h042;
   localparam logic [IDX_W-1:0] IDX_L4_VOLT = 10'h050;
   localparam logic [IDX_W-1:0] IDX_L4_CTRL = 10'h051;
   localparam logic [IDX_W-1:0] IDX_IRQ_STAT = 10'h070;
   localparam logic [IDX_W-1:0] IDX_IRQ_MASK = 10'h071;
   localparam logic [1:0] WORD_ALIGN = 2'h0;

   // control register field positions
   localparam int unsigned CTL_ON = 7;
   localparam int unsigned CTL_PHASE = 6;
   localparam int unsigned CTL_DIS = 6;
   localparam int unsigned CTL_MODE = 5;
   localparam int unsigned CTL_LOW_QUIESCENT_SELECT = 5;
   localparam int unsigned CTL_DLY_HI = 4;
   localparam int unsigned CTL_DLY_LO = 2;
   localparam int unsigned CTL_UNMASK = 1;
   localparam int unsigned CTL_OK = 0;

   // channel slots in the event and status vectors
   localparam int unsigned CH_B2 = 0;
   localparam int unsigned CH_B3 = 1;
   localparam int unsigned CH_L4 = 2;

   // values after reset (power loss)
   localparam logic [VCODE_W-1:0] RST_VCODE = 6'h00;
   localparam logic [REG_W-1:1] RST_CTRL = 7'h00;
   localparam logic [NUM_CH-1:0] RST_MASK = 3'h0;
   localparam logic [NUM_CH-1:0] RST_STAT = 3'h0;
   localparam logic [DATA_W-1:0] RST_RDATA = 32'h0000_0000;

   typedef enum logic {
      APB_IDLE = 1'b0,
      APB_ACK = 1'b1
   } rcr_apb_e;

endpackage

// [design/rcr_chan_if.sv]
// carrier between the register bank and one regulator channel
`timescale 1ns/1ps
`default_nettype none
interface rcr_chan_if;
   import rcr_pkg::*;
   logic ctrl_we;
   logic [REG_W-1:0] wdata;
   logic pgood;
   logic [REG_W-1:0] ctrl;
   logic fault_evt;
   modport bank (output ctrl_we, output wdata, output pgood,
                 input ctrl, input fault_evt);
   modport chan (input ctrl_we, input wdata, input pgood,
                 output ctrl, output fault_evt);
endinterface
`default_nettype wire

// [design/rcr_chan.sv]
// one channel: control register, power-good tracking, fault event
`timescale 1ns/1ps
`default_nettype none
module rcr_chan
   import rcr_pkg::*;
#(
   parameter logic [REG_W-1:1] RST_VAL = RST_CTRL
) (
   input wire logic clk,
   input wire logic rst_n,
   rcr_chan_if.chan ch
);
   logic [REG_W-1:1] ctrl_ff;
   logic pg_ff;
   logic pg_d_ff;
   logic fault_ff;
   logic pg_fell;
   logic nxt_fault;

   assign pg_fell = pg_d_ff & ~pg_ff;
   assign nxt_fault = pg_fell & ctrl_ff[CTL_ON] & ctrl_ff[CTL_UNMASK]; // [R13] [R7]
   assign ch.ctrl = {ctrl_ff, pg_ff}; // [R8]
   assign ch.fault_evt = fault_ff;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         ctrl_ff <= RST_VAL; // [R12]
         pg_ff <= 1'b0;
         pg_d_ff <= 1'b0;
         fault_ff <= 1'b0;
      end else begin
         // bit 0 is status only, never stored from a write
         if (ch.ctrl_we) ctrl_ff <= ch.wdata[REG_W-1:1]; // [R6] [R7]
         pg_ff <= ch.pgood; // [R8]
         pg_d_ff <= pg_ff;
         fault_ff <= nxt_fault;
      end
   end
endmodule
`default_nettype wire

// [design/rcr_irq.sv]
// sticky fault status with read-clear, mask and level interrupt
`timescale 1ns/1ps
`default_nettype none
module rcr_irq
   import rcr_pkg::*;
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [NUM_CH-1:0] evt,
   input wire logic [NUM_CH-1:0] clr_bits,
   input wire logic mask_we,
   input wire logic [NUM_CH-1:0] mask_wdata,
   output logic [NUM_CH-1:0] stat,
   output logic [NUM_CH-1:0] mask,
   output logic irq
);
   logic [NUM_CH-1:0] stat_ff;
   logic [NUM_CH-1:0] mask_ff;
   logic irq_ff;
   logic [NUM_CH-1:0] nxt_stat;
   logic [NUM_CH-1:0] nxt_mask;

   // set wins: only bits that were returned by the read are cleared
   assign nxt_stat = (stat_ff & ~clr_bits) | evt;
   assign nxt_mask = mask_we ? mask_wdata : mask_ff;
   assign stat = stat_ff;
   assign mask = mask_ff;
   assign irq = irq_ff;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         stat_ff <= RST_STAT;
         mask_ff <= RST_MASK;
         irq_ff <= 1'b0;
      end else begin
         stat_ff <= nxt_stat;
         mask_ff <= nxt_mask;
         irq_ff <= |(nxt_stat & nxt_mask); // [R13]
      end
   end
endmodule
`default_nettype wire

// [design/rcr_top.sv]
// regulator control register bank with apb slave
//
// Summary of operation
// R1 - select pin low: primary code drives output
// R2 - select pin high: secondary code drives output
// R3 - control bit 7 enables the regulator
// R4 - channel two bit 6 selects antiphase switching
// R5 - bit 5 forces pwm, else power save
// R6 - bits 4:2 hold turn-on delay
// R7 - bit 1 unmasks channel fault interrupts
// R8 - bit 0 reads live power-good status
// R9 - linear bit 6 discharges output when off
// R10 - linear bit 5 selects low quiescent mode
// R11 - linear has one code, ignores select
// R12 - power loss restores every default
// R13 - enabled power-good fall raises fault interrupt
//
// The implementer's own choice: the APB register port.
`timescale 1ns/1ps
`default_nettype none
module rcr_top
   import rcr_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [rcr_pkg::ADDR_W-1:0] paddr,
   input wire logic [rcr_pkg::DATA_W-1:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [rcr_pkg::DATA_W-1:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic voltage_set_select_pin,
   input wire logic [rcr_pkg::NUM_CH-1:0] power_good_in,
   output logic [rcr_pkg::VCODE_W-1:0] step_down_two_vcode,
   output logic step_down_two_enable,
   output logic step_down_two_antiphase,
   output logic step_down_two_pwm_force,
   output logic [rcr_pkg::DLY_W-1:0] step_down_two_delay,
   output logic [rcr_pkg::VCODE_W-1:0] step_down_three_vcode,
   output logic step_down_three_enable,
   output logic step_down_three_pwm_force,
   output logic [rcr_pkg::DLY_W-1:0] step_down_three_delay,
   output logic [rcr_pkg::VCODE_W-1:0] linear_four_vcode,
   output logic linear_four_enable,
   output logic output_discharge_enable,
   output logic low_quiescent_select,
   output logic [rcr_pkg::DLY_W-1:0] linear_four_delay,
   output logic fault_irq
);
   import rcr_pkg::*;

   rcr_chan_if b2_if ();
   rcr_chan_if b3_if ();
   rcr_chan_if l4_if ();

   // bus state and registered answer
   rcr_apb_e state_ff;
   rcr_apb_e nxt_state;
   logic [DATA_W-1:0] prdata_ff;
   logic pslverr_ff;

   // voltage code storage
   logic [VCODE_W-1:0] b2_main_ff;
   logic [VCODE_W-1:0] b2_alt_ff;
   logic [VCODE_W-1:0] b3_main_ff;
   logic [VCODE_W-1:0] b3_alt_ff;
   logic [VCODE_W-1:0] l4_code_ff;

   // registered pin-facing outputs
   logic [VCODE_W-1:0] b2_vcode_ff;
   logic [VCODE_W-1:0] b3_vcode_ff;
   logic [VCODE_W-1:0] l4_vcode_ff;
   logic discharge_ff;

   // decode
   logic [IDX_W-1:0] idx;
   logic aligned;
   logic hit_b2_main;
   logic hit_b2_alt;
   logic hit_b2_ctrl;
   logic hit_b3_main;
   logic hit_b3_alt;
   logic hit_b3_ctrl;
   logic hit_l4_volt;
   logic hit_l4_ctrl;
   logic hit_stat;
   logic hit_mask;
   logic hit_any;

   // access phase strobes
   logic setup_seen;
   logic done;
   logic wr_go;
   logic rd_done;

   // read path
   logic [REG_W-1:0] rd_byte;
   logic [DATA_W-1:0] rd_word;
   logic [DATA_W-1:0] nxt_prdata;
   logic nxt_pslverr;

   // next values of the pin-facing outputs
   logic [VCODE_W-1:0] nxt_b2_vcode;
   logic [VCODE_W-1:0] nxt_b3_vcode;
   logic nxt_discharge;

   // interrupt block wiring
   logic [NUM_CH-1:0] fault_evt;
   logic [NUM_CH-1:0] stat_clr;
   logic [NUM_CH-1:0] irq_stat;
   logic [NUM_CH-1:0] irq_mask;
   logic irq_level;

   // ---------------------------------------------------------------
   // address decode: misaligned byte addresses never hit
   assign idx = paddr[ADDR_W-1:2];
   assign aligned = (paddr[1:0] == WORD_ALIGN);
   assign hit_b2_main = aligned & (idx == IDX_B2_MAIN);
   assign hit_b2_alt = aligned & (idx == IDX_B2_ALT);
   assign hit_b2_ctrl = aligned & (idx == IDX_B2_CTRL);
   assign hit_b3_main = aligned & (idx == IDX_B3_MAIN);
   assign hit_b3_alt = aligned & (idx == IDX_B3_ALT);
   assign hit_b3_ctrl = aligned & (idx == IDX_B3_CTRL);
   assign hit_l4_volt = aligned & (idx == IDX_L4_VOLT);
   assign hit_l4_ctrl = aligned & (idx == IDX_L4_CTRL);
   assign hit_stat = aligned & (idx == IDX_IRQ_STAT);
   assign hit_mask = aligned & (idx == IDX_IRQ_MASK);
   assign hit_any = hit_b2_main | hit_b2_alt | hit_b2_ctrl | hit_b3_main
                  | hit_b3_alt | hit_b3_ctrl | hit_l4_volt | hit_l4_ctrl
                  | hit_stat | hit_mask;

   // ---------------------------------------------------------------
   // one wait state: pready rises in the second access cycle
   assign setup_seen = psel & penable & (state_ff == APB_IDLE);
   assign done = psel & penable & (state_ff == APB_ACK);
   assign nxt_state = setup_seen ? APB_ACK : APB_IDLE;

   // only the low byte lane carries register data
   assign wr_go = done & pwrite & pstrb[0] & hit_any;
   assign rd_done = done & ~pwrite & hit_stat;

   // ---------------------------------------------------------------
   // read mux; reserved bits read as zero, except sd3 control bit 6, which reads back as written
   assign rd_byte =
      hit_b2_main ? {2'h0, b2_main_ff} :
      hit_b2_alt ? {2'h0, b2_alt_ff} :
      hit_b2_ctrl ? b2_if.ctrl :
      hit_b3_main ? {2'h0, b3_main_ff} :
      hit_b3_alt ? {2'h0, b3_alt_ff} :
      hit_b3_ctrl ? b3_if.ctrl :
      hit_l4_volt ? {2'h0, l4_code_ff} :
      hit_l4_ctrl ? l4_if.ctrl :
      hit_stat ? {5'h00, irq_stat} :
      hit_mask ? {5'h00, irq_mask} :
      8'h00;
   assign rd_word = {24'h00_0000, rd_byte};

   // data is captured when pready is raised and held through the answer
   assign nxt_prdata = (setup_seen & ~pwrite) ? rd_word : prdata_ff;
   assign nxt_pslverr = setup_seen & ~hit_any;

   // ---------------------------------------------------------------
   // channel write strobes and power-good feeds
   assign b2_if.ctrl_we = wr_go & hit_b2_ctrl; // [R3]
   assign b2_if.wdata = pwdata[REG_W-1:0];
   assign b2_if.pgood = power_good_in[CH_B2];
   assign b3_if.ctrl_we = wr_go & hit_b3_ctrl; // [R3]
   assign b3_if.wdata = pwdata[REG_W-1:0];
   assign b3_if.pgood = power_good_in[CH_B3];
   assign l4_if.ctrl_we = wr_go & hit_l4_ctrl; // [R3]
   assign l4_if.wdata = pwdata[REG_W-1:0];
   assign l4_if.pgood = power_good_in[CH_L4];

   rcr_chan #(
      .RST_VAL(RST_CTRL)
   ) u_b2 (
      .clk(pclk),
      .rst_n(presetn),
      .ch(b2_if)
   );

   rcr_chan #(
      .RST_VAL(RST_CTRL)
   ) u_b3 (
      .clk(pclk),
      .rst_n(presetn),
      .ch(b3_if)
   );

   rcr_chan #(
      .RST_VAL(RST_CTRL)
   ) u_l4 (
      .clk(pclk),
      .rst_n(presetn),
      .ch(l4_if)
   );

   // ---------------------------------------------------------------
   // fault interrupts; a status read clears only what it returned
   assign fault_evt = {l4_if.fault_evt, b3_if.fault_evt, b2_if.fault_evt};
   assign stat_clr = rd_done ? prdata_ff[NUM_CH-1:0] : RST_STAT;

   rcr_irq u_irq (
      .clk(pclk),
      .rst_n(presetn),
      .evt(fault_evt),
      .clr_bits(stat_clr),
      .mask_we(wr_go & hit_mask),
      .mask_wdata(pwdata[NUM_CH-1:0]),
      .stat(irq_stat),
      .mask(irq_mask),
      .irq(irq_level)
   );

   // ---------------------------------------------------------------
   // output code selection, registered so the pins come from flops
   assign nxt_b2_vcode = voltage_set_select_pin ? b2_alt_ff
                                                : b2_main_ff; // [R1] [R2]
   assign nxt_b3_vcode = voltage_set_select_pin ? b3_alt_ff
                                                : b3_main_ff; // [R1] [R2]
   // discharge path only while the linear channel is shut down
   assign nxt_discharge = l4_if.ctrl[CTL_DIS]
                        & ~l4_if.ctrl[CTL_ON]; // [R9]

   // ---------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_ff <= APB_IDLE;
         prdata_ff <= RST_RDATA;
         pslverr_ff <= 1'b0;
      end else begin
         state_ff <= nxt_state;
         prdata_ff <= nxt_prdata;
         pslverr_ff <= nxt_pslverr;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         b2_main_ff <= RST_VCODE; // [R12]
         b2_alt_ff <= RST_VCODE;
         b3_main_ff <= RST_VCODE;
         b3_alt_ff <= RST_VCODE;
         l4_code_ff <= RST_VCODE;
      end else begin
         if (wr_go & hit_b2_main) b2_main_ff <= pwdata[VCODE_W-1:0]; // [R1]
         if (wr_go & hit_b2_alt) b2_alt_ff <= pwdata[VCODE_W-1:0]; // [R2]
         if (wr_go & hit_b3_main) b3_main_ff <= pwdata[VCODE_W-1:0]; // [R1]
         if (wr_go & hit_b3_alt) b3_alt_ff <= pwdata[VCODE_W-1:0]; // [R2]
         if (wr_go & hit_l4_volt) l4_code_ff <= pwdata[VCODE_W-1:0]; // [R11]
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         b2_vcode_ff <= RST_VCODE;
         b3_vcode_ff <= RST_VCODE;
         l4_vcode_ff <= RST_VCODE;
         discharge_ff <= 1'b0;
      end else begin
         b2_vcode_ff <= nxt_b2_vcode;
         b3_vcode_ff <= nxt_b3_vcode;
         // no alternate code here, the select pin is not consulted
         l4_vcode_ff <= l4_code_ff; // [R11]
         discharge_ff <= nxt_discharge;
      end
   end

   // ---------------------------------------------------------------
   assign prdata = prdata_ff;
   assign pready = (state_ff == APB_ACK);
   assign pslverr = pslverr_ff;

   assign step_down_two_vcode = b2_vcode_ff;
   assign step_down_two_enable = b2_if.ctrl[CTL_ON]; // [R3]
   assign step_down_two_antiphase = b2_if.ctrl[CTL_PHASE]; // [R4]
   assign step_down_two_pwm_force = b2_if.ctrl[CTL_MODE]; // [R5]
   assign step_down_two_delay =
      b2_if.ctrl[CTL_DLY_HI:CTL_DLY_LO]; // [R6]

   // bit 6 of this channel is stored but drives nothing
   assign step_down_three_vcode = b3_vcode_ff;
   assign step_down_three_enable = b3_if.ctrl[CTL_ON]; // [R3]
   assign step_down_three_pwm_force = b3_if.ctrl[CTL_MODE]; // [R5]
   assign step_down_three_delay =
      b3_if.ctrl[CTL_DLY_HI:CTL_DLY_LO]; // [R6]

   assign linear_four_vcode = l4_vcode_ff;
   assign linear_four_enable = l4_if.ctrl[CTL_ON]; // [R3]
   assign output_discharge_enable = discharge_ff;
   assign low_quiescent_select = l4_if.ctrl[CTL_LOW_QUIESCENT_SELECT]; // [R10]
   assign linear_four_delay =
      l4_if.ctrl[CTL_DLY_HI:CTL_DLY_LO]; // [R6]

   assign fault_irq = irq_level;

endmodule
`default_nettype wire

// [dv/rcr_top_asserts.sv]
// port assertions for the regulator control register bank
`timescale 1ns/1ps
`default_nettype none
module rcr_top_chk
   import rcr_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic pready,
   input wire logic voltage_set_select_pin,
   input wire logic [rcr_pkg::VCODE_W-1:0] step_down_two_vcode,
   input wire logic step_down_two_enable,
   input wire logic step_down_two_antiphase,
   input wire logic step_down_two_pwm_force,
   input wire logic [rcr_pkg::DLY_W-1:0] step_down_two_delay,
   input wire logic [rcr_pkg::VCODE_W-1:0] linear_four_vcode,
   input wire logic linear_four_enable,
   input wire logic output_discharge_enable,
   input wire logic low_quiescent_select,
   input wire logic fault_irq
);
   logic done;
   logic wc;
   assign done = psel && penable && pready;
   assign wc = done && pwrite;
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   a_ready_wait: assert property ($rose(penable) && psel |-> !pready ##1 pready)
      else $error("pready not after one wait state");
   a_ready_once: assert property (pready |=> !pready)
      else $error("pready held longer than one cycle");
   a_reset_quiet: assert property (disable iff (1'b0) !presetn |->
      !pready && !fault_irq && step_down_two_vcode == '0)
      else $error("outputs active during reset");
   a_buck_code: assert property (!wc ##1 !wc &&
      $stable(voltage_set_select_pin) |=> $stable(step_down_two_vcode))
      else $error("step-down code moved without cause");
   a_link_code: assert property (!wc ##1 !wc |=>
      $stable(linear_four_vcode))
      else $error("linear code moved without a write");
   a_ctrl_hold: assert property (!wc ##1 !wc |=>
      $stable({step_down_two_enable, step_down_two_antiphase,
      step_down_two_pwm_force, step_down_two_delay, low_quiescent_select}))
      else $error("control output moved without a write");
   a_dis_when_off: assert property (linear_four_enable &&
      $past(linear_four_enable) |-> !output_discharge_enable)
      else $error("discharge on while regulator enabled");
   a_irq_sticky: assert property ($fell(fault_irq) |->
      $past(done) || $past(done, 2))
      else $error("interrupt dropped without an access");
endmodule
bind rcr_top rcr_top_chk i_rcr_top_chk (.pclk, .presetn, .psel, .penable,
   .pwrite, .pready, .voltage_set_select_pin, .step_down_two_vcode,
   .step_down_two_enable, .step_down_two_antiphase, .step_down_two_pwm_force,
   .step_down_two_delay, .linear_four_vcode, .linear_four_enable,
   .output_discharge_enable, .low_quiescent_select, .fault_irq);
`default_nettype wire

// [dv/testbench.sv]
// self-checking bench for the regulator control register bank
`timescale 1ns/1ps
`default_nettype none
module testbench;
   import rcr_pkg::*;
   logic pclk = 0;
   logic presetn = 1;
   logic psel = 0, penable = 0, pwrite = 0;
   logic [11:0] paddr = '0;
   logic [31:0] pwdata = '0;
   logic [3:0] pstrb = 4'hf;
   logic pin = 0;
   logic [2:0] pg = 3'h0;
   logic [31:0] prdata, rd_v;
   logic pready, pslverr, rd_e, s2_en, s2_ph, s2_pm, s3_en, s3_pm;
   logic l4_en, dis, lowq, irq;
   logic [5:0] s2_v, s3_v, l4_v;
   logic [2:0] s2_d, s3_d, l4_d;
   int bad_count = 0, num_checks = 0;
   logic [11:0] t_a [10] = '{12'h0c0, 12'h0c4, 12'h0c8, 12'h100, 12'h104,
      12'h108, 12'h140, 12'h144, 12'h1c4, 12'h1c0};
   logic [7:0] t_w [10] = '{8'hea, 8'h15, 8'hb7, 8'h3f, 8'h01, 8'h6a, 8'h33,
      8'h58, 8'hfa, 8'h07};
   logic [7:0] t_e [10] = '{8'h2a, 8'h15, 8'hb6, 8'h3f, 8'h01, 8'h6a, 8'h33,
      8'h58, 8'h02, 8'h00};
   always #5 pclk = ~pclk;
   rcr_top i_rcr_top (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
      .pwdata, .pstrb, .prdata, .pready, .pslverr,
      .voltage_set_select_pin(pin), .power_good_in(pg),
      .step_down_two_vcode(s2_v), .step_down_two_enable(s2_en),
      .step_down_two_antiphase(s2_ph), .step_down_two_pwm_force(s2_pm),
      .step_down_two_delay(s2_d), .step_down_three_vcode(s3_v),
      .step_down_three_enable(s3_en), .step_down_three_pwm_force(s3_pm),
      .step_down_three_delay(s3_d), .linear_four_vcode(l4_v),
      .linear_four_enable(l4_en), .output_discharge_enable(dis),
      .low_quiescent_select(lowq), .linear_four_delay(l4_d),
      .fault_irq(irq));
   task automatic wrap_up();
      $display("checks %0d mismatches %0d", num_checks, bad_count);
      if (bad_count == 0 && num_checks > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   task automatic chk(input string n, input logic [31:0] e,
         input logic [31:0] g);
      num_checks++;
      if (g !== e) begin
         bad_count++;
         $display("MISMATCH %s expected %h seen %h", n, e, g);
      end
   endtask
   // pready and the answer are taken at the rising edge that completes
   task automatic apb(input logic w, input logic [11:0] a,
         input logic [31:0] d);
      int n;
      n = 0;
      @(posedge pclk);
      psel <= 1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      if (pready !== 1'b1) begin
         bad_count++;
         $display("MISMATCH pready expected 1 seen %b", pready);
      end
      rd_v = prdata;
      rd_e = pslverr;
      psel <= 0;
      penable <= 0;
   endtask
   task automatic rd(input logic [11:0] a, input logic [7:0] e,
         input string n);
      apb(0, a, 0);
      chk(n, {24'h00_0000, e}, rd_v);
   endtask
   task automatic pg_drop();
      @(posedge pclk);
      pg[0] <= 1;
      repeat (4) @(negedge pclk);
      @(posedge pclk);
      pg[0] <= 0;
      repeat (6) @(negedge pclk);
   endtask
   initial begin
      #100000;
      bad_count++;
      wrap_up();
   end
   initial begin
      // falling edge at time zero clears the flops before the first clock
      presetn <= 0;
      repeat (20) @(posedge pclk);
      presetn <= 1;
      for (int i = 0; i < 10; i++) begin
         rd(t_a[i], 8'h00, "reset value");
         apb(1, t_a[i], t_w[i]);
         rd(t_a[i], t_e[i], "readback");
      end
      chk("sd2 code lo", 6'h2a, s2_v);
      chk("sd3 code lo", 6'h3f, s3_v);
      @(posedge pclk);
      pin <= 1;
      repeat (3) @(negedge pclk);
      chk("sd2 code hi", 6'h15, s2_v);
      chk("sd3 code hi", 6'h01, s3_v);
      chk("l4 code", 6'h33, l4_v);
      chk("sd2 ctl", 6'h2d, {s2_en, s2_ph, s2_pm, s2_d});
      chk("sd3 ctl", 5'h0a, {s3_en, s3_pm, s3_d});
      chk("l4 ctl", 6'h16, {l4_en, dis, lowq, l4_d});
      @(posedge pclk);
      pg <= 3'h7;
      rd(12'h0c8, 8'hb7, "sd2 ok bit");
      rd(12'h144, 8'h59, "l4 ok bit");
      apb(1, 12'h1c4, 8'h00);
      pg_drop();
      chk("irq masked", 1'b0, irq);
      apb(1, 12'h1c4, 8'h01);
      repeat (2) @(negedge pclk);
      chk("irq raised", 1'b1, irq);
      rd(12'h1c0, 8'h01, "fault status");
      repeat (2) @(negedge pclk);
      chk("irq cleared", 1'b0, irq);
      rd(12'h1c0, 8'h00, "status after read");
      apb(1, 12'h0c8, 8'hc0);
      apb(1, 12'h144, 8'hf8);
      repeat (2) @(negedge pclk);
      chk("sd2 ctl 2", 6'h30, {s2_en, s2_ph, s2_pm, s2_d});
      chk("l4 ctl 2", 6'h2e, {l4_en, dis, lowq, l4_d});
      // unmask bit now clear, so the same fall must leave status empty
      pg_drop();
      rd(12'h1c0, 8'h00, "fault with unmask clear");
      pstrb <= 4'h0;
      apb(1, 12'h140, 8'h11);
      pstrb <= 4'hf;
      rd(12'h140, 8'h33, "write with lane off");
      apb(0, 12'h200, 0);
      chk("unmapped data", 32'h0000_0000, rd_v);
      chk("unmapped err", 1'b1, rd_e);
      @(posedge pclk);
      presetn <= 0;
      repeat (3) @(negedge pclk);
      chk("irq in reset", 1'b0, irq);
      chk("sd2 en in reset", 1'b0, s2_en);
      chk("l4 out in reset", 6'h00, l4_v);
      @(posedge pclk);
      presetn <= 1;
      rd(12'h0c8, 8'h00, "sd2 ctl after reset");
      rd(12'h140, 8'h00, "l4 code after reset");
      chk("l4 out after reset", 6'h00, l4_v);
      wrap_up();
   end
endmodule
`default_nettype wire
